/* bench/tb.sv */
// Self-checking bench for the timer, watchdog and wake control block
module tb;
	timeunit 1ns;
	timeprecision 100ps;
	import twk_pkg::*;
	typedef struct {logic pg; logic [3:0] a; logic [7:0] d; logic [7:0] e;} twk_row_t;
	logic clk = 1'b0;
	logic nrst = 1'b0;
	logic ce = 1'b1;
	twk_reg_req_t req = '0;
	logic [7:0] ev = '0;
	logic tickPin = 1'b0, irqPin = 1'b0, subOsc = 1'b0, mainOsc = 1'b0;
	logic [7:0] rdData, d;
	logic rdValid, irDrive, irqEn, extIrq, tickP, c1Tick, c2Tick, wdRst;
	logic [3:0] wakeDis;
	int miscompares = 0, compares = 0, cycles = 0;
	int nTick = 0, nIrq = 0, nC1 = 0, nC2 = 0, nWd = 0;
	// Write, then read back from the same place
	twk_row_t rows[6] = '{'{1'b1, 4'h6, 8'hFF, 8'h8F}, '{1'b1, 4'h7, 8'h7F, 8'h3F},
		'{1'b1, 4'h8, 8'hFF, 8'h0F}, '{1'b1, 4'h9, 8'hA5, 8'hA5},
		'{1'b0, 4'h9, 8'h5A, 8'hA5}, '{1'b1, 4'hA, 8'hFF, 8'h00}};
	logic [7:0] tv[4] = '{8'h80, 8'h88, 8'h89, 8'h8F};
	int ex[4] = '{256, 128, 64, 1};
	int seq[4] = '{6, 5, 7, 4};

	// 250 MHz core clock
	always #2 clk = ~clk;

	twk_control u_dut (
		.clk(clk), .nrst(nrst), .ce(ce),
		.regReq(req), .regRdData(rdData), .regRdValid(rdValid),
		.instrTick(ev[0]), .tickCounterWrite(ev[1]),
		.irqDisableInstruction(ev[4]), .irqEntry(ev[5]),
		.irqEnableInstruction(ev[6]), .irqReturnInstruction(ev[7]),
		.watchdogClearInstruction(ev[2]), .sleepInstruction(ev[3]),
		.extTickPin(tickPin), .extIrqPinZero(irqPin),
		.subOscClock(subOsc), .mainOscClock(mainOsc),
		.irPinDriveSelect(irDrive), .wakeDisable(wakeDis), .globalIrqEnable(irqEn),
		.extIrqPulse(extIrq), .tickPulse(tickP), .counterOneTick(c1Tick),
		.counterTwoTick(c2Tick), .watchdogReset(wdRst)
	);

	// Pulse counters, sampled mid-cycle so bench clears never race them
	always @(negedge clk) begin
		nTick += int'(tickP);
		nIrq += int'(extIrq);
		nC1 += int'(c1Tick);
		nC2 += int'(c2Tick);
		nWd += int'(wdRst);
		cycles++;
		if (cycles == 20000) begin
			miscompares++;
			final_report();
		end
	end

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		compares++;
		if (got !== exp) begin
			miscompares++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task automatic wr(input logic pg, input logic [3:0] a, input logic [7:0] v);
		@(posedge clk);
		req <= '{wr: 1'b1, rd: 1'b0, page: pg, addr: a, wdata: v};
		@(posedge clk);
		req <= '0;
	endtask : wr

	// Read answer lands one cycle after the request edge
	task automatic rd(input logic [3:0] a, output logic [7:0] v);
		@(posedge clk);
		req <= '{wr: 1'b0, rd: 1'b1, page: 1'b1, addr: a, wdata: 8'h00};
		@(posedge clk);
		req <= '0;
		#1;
		chk({15'h0, rdValid}, 16'h0001);
		v = rdData;
	endtask : rd

	// One-cycle event pulse on bit k
	task automatic pulse(input int k);
		@(posedge clk);
		ev[k] <= 1'b1;
		@(posedge clk);
		ev <= '0;
	endtask : pulse

	// Oscillator edges, slow against the core clock
	task automatic edges(input int n, input bit useMain);
		repeat (n) begin
			repeat (4) @(posedge clk);
			if (useMain) mainOsc <= 1'b1; else subOsc <= 1'b1;
			repeat (4) @(posedge clk);
			if (useMain) mainOsc <= 1'b0; else subOsc <= 1'b0;
		end
	endtask : edges

	// Pin high then low, each phase far longer than an instruction
	task automatic pin(input bit isIrq, input int r, input int f);
		nTick = 0;
		nIrq = 0;
		@(posedge clk);
		if (isIrq) irqPin <= 1'b1; else tickPin <= 1'b1;
		repeat (8) @(posedge clk);
		chk(16'(isIrq ? nIrq : nTick), 16'(r));
		if (isIrq) irqPin <= 1'b0; else tickPin <= 1'b0;
		repeat (8) @(posedge clk);
		chk(16'(isIrq ? nIrq : nTick), 16'(r + f));
	endtask : pin

	task automatic final_report;
		$display("Comparisons %0d, mismatches %0d", compares, miscompares);
		if (miscompares == 0 && compares > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : final_report

	// Main sequence
	initial begin
		repeat (8) @(posedge clk);
		chk({8'h00, irDrive, 3'h0, wakeDis}, 16'h0000);
		nrst <= 1'b1;
		rd(ADDR_WAKE, d);
		chk({8'h00, d}, 16'h0000);
		rd(ADDR_TICK, d);
		chk({8'h00, d}, 16'h00BF);
		foreach (rows[i]) begin
			wr(rows[i].pg, rows[i].a, rows[i].d);
			rd(rows[i].a, d);
			chk({8'h00, d}, {8'h00, rows[i].e});
		end
		// Enable held low drops a write
		@(posedge clk);
		ce <= 1'b0;
		wr(1'b1, ADDR_WAKE, 8'h00);
		ce <= 1'b1;
		rd(ADDR_WAKE, d);
		chk({8'h00, d}, 16'h008F);
		// Page zero read answers zero with valid
		@(posedge clk);
		req <= '{wr: 1'b0, rd: 1'b1, page: 1'b0, addr: ADDR_WAKE, wdata: 8'h00};
		@(posedge clk);
		req <= '0;
		#1;
		chk({7'h00, rdValid, rdData}, 16'h0100);
		// Wake drive and nibble disables reach the outputs
		wr(1'b1, ADDR_WAKE, 8'h85);
		#1;
		chk({8'h00, irDrive, 3'h0, wakeDis}, 16'h0085);
		// Interrupt enable follows the instruction events
		foreach (seq[k]) begin
			pulse(seq[k]);
			rd(ADDR_TICK, d);
			chk({14'h0000, irqEn, d[6]}, (seq[k] > 5) ? 16'h0003 : 16'h0000);
		end
		// Prescale ratios on the instruction clock, 256 ticks each
		foreach (tv[i]) begin
			wr(1'b1, ADDR_TICK, tv[i]);
			pulse(1);
			nTick = 0;
			repeat (256) pulse(0);
			repeat (4) @(posedge clk);
			chk(16'(nTick), 16'(ex[i]));
		end
		// A counter write drops the half-done prescale step
		wr(1'b1, ADDR_TICK, 8'h88);
		pulse(1);
		nTick = 0;
		pulse(0);
		pulse(1);
		pulse(0);
		repeat (4) @(posedge clk);
		chk(16'(nTick), 16'h0000);
		// External pin source and both edge choices
		for (int e = 0; e < 2; e++) begin
			wr(1'b1, ADDR_TICK, (e == 1) ? 8'hB0 : 8'h20);
			pin(1'b0, 1 - e, e);
			pin(1'b1, 1 - e, e);
		end
		// Counter clocks: two on main at 1:2, one on sub at 1:4
		wr(1'b1, ADDR_WDOG, 8'h00);
		wr(1'b1, ADDR_CNT, 8'h81);
		nC1 = 0;
		nC2 = 0;
		edges(16, 1'b1);
		chk({nC2[7:0], nC1[7:0]}, 16'h0800);
		edges(16, 1'b0);
		chk({nC2[7:0], nC1[7:0]}, 16'h0804);
		chk(16'(nWd), 16'h0000);
		// Watchdog 1:1 needs 512 sub edges; sleep mid-way restarts it
		wr(1'b1, ADDR_WDOG, 8'h08);
		pulse(2);
		nWd = 0;
		edges(300, 1'b0);
		pulse(3);
		edges(508, 1'b0);
		chk(16'(nWd), 16'h0000);
		edges(6, 1'b0);
		chk(16'(nWd), 16'h0001);
		// Reset in mid-run brings the wake and tick registers and the interrupt enable back
		@(posedge clk);
		nrst <= 1'b0;
		@(posedge clk);
		chk({7'h00, irqEn, irDrive, 3'h0, wakeDis}, 16'h0000);
		nrst <= 1'b1;
		rd(ADDR_WAKE, d);
		chk({8'h00, d}, 16'h0000);
		rd(ADDR_TICK, d);
		chk({8'h00, d}, 16'h00BF);
		final_report();
	end
endmodule : tb

/* rtl/twk_control.sv */
// Timer, watchdog, counter clock and wake control registers with their tick logic
module twk_control (
	// Clock, enable and reset
	input wire logic clk,
	input wire logic nrst,
	input wire logic ce,
	// Register access from the core
	input wire twk_pkg::twk_reg_req_t regReq,
	output logic [7:0] regRdData,
	output logic regRdValid,
	// Core instruction events, one-cycle pulses
	input wire logic instrTick,
	input wire logic tickCounterWrite,
	input wire logic irqDisableInstruction,
	input wire logic irqEntry,
	input wire logic irqEnableInstruction,
	input wire logic irqReturnInstruction,
	input wire logic watchdogClearInstruction,
	input wire logic sleepInstruction,
	// Pins and oscillators, asynchronous
	input wire logic extTickPin,
	input wire logic extIrqPinZero,
	input wire logic subOscClock,
	input wire logic mainOscClock,
	// Configuration outputs
	output logic irPinDriveSelect,
	output logic [3:0] wakeDisable,
	output logic globalIrqEnable,
	// Event outputs, one-cycle pulses
	output logic extIrqPulse,
	output logic tickPulse,
	output logic counterOneTick,
	output logic counterTwoTick,
	output logic watchdogReset
);
	import twk_pkg::*;

	logic [7:0] wake_reg, wake_next;
	logic [7:0] tick_reg, tick_next;
	logic [7:0] wdog_reg, wdog_next;
	logic [7:0] cnt_reg, cnt_next;
	logic [3:0] syncA_reg, syncB_reg, prev_reg;
	logic [3:0] rise, fall;
	logic irqEn_reg, irqEn_next;
	logic extIrq_reg, extIrq_next;
	logic [7:0] rd_reg, rd_next;
	logic rdValid_reg, rdValid_next;
	logic half_reg, half_next;
	logic [7:0] wdCnt_reg, wdCnt_next;
	logic wdRst_reg, wdRst_next;
	logic tickSrc, wdHalfTick, wdClear, wdStep;
	logic cnt1Src, cnt2Src;
	logic [3:0] tickShift;

	// Register writes; reserved and read-only bits are masked off
	always_comb begin
		wake_next = wake_reg;
		tick_next = tick_reg;
		wdog_next = wdog_reg;
		cnt_next = cnt_reg;
		if (regReq.wr && twk_hit(regReq, ADDR_WAKE)) begin // [RULE1]
			wake_next = regReq.wdata & WAKE_MASK; // [RULE2] [RULE3] [RULE21]
		end
		if (regReq.wr && twk_hit(regReq, ADDR_TICK)) begin // [RULE1]
			tick_next = regReq.wdata & TICK_MASK; // [RULE6]
		end
		if (regReq.wr && twk_hit(regReq, ADDR_WDOG)) begin // [RULE1]
			wdog_next = regReq.wdata & WDOG_MASK; // [RULE21]
		end
		if (regReq.wr && twk_hit(regReq, ADDR_CNT)) begin // [RULE1]
			cnt_next = regReq.wdata & CNT_MASK;
		end
	end

	// Register storage; wake groups come up enabled, tick control all ones except bit 6
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			wake_reg <= WAKE_RST; // [RULE4]
			tick_reg <= TICK_RST; // [RULE20]
			wdog_reg <= WDOG_RST;
			cnt_reg <= CNT_RST;
		end else if (ce) begin
			wake_reg <= wake_next;
			tick_reg <= tick_next;
			wdog_reg <= wdog_next;
			cnt_reg <= cnt_next;
		end
	end

	// Pin synchronisers: bit 0 tick pin, 1 irq pin, 2 sub osc, 3 main osc
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			syncA_reg <= 4'h0;
			syncB_reg <= 4'h0;
			prev_reg <= 4'h0;
		end else if (ce) begin
			syncA_reg <= {mainOscClock, subOscClock, extIrqPinZero, extTickPin};
			syncB_reg <= syncA_reg;
			prev_reg <= syncB_reg;
		end
	end

	// Edge detection only on the second stage
	assign rise = syncB_reg & ~prev_reg;
	assign fall = ~syncB_reg & prev_reg;

	// Global interrupt enable copy; a disable in the same cycle as an enable wins
	always_comb begin
		irqEn_next = irqEn_reg;
		if (irqDisableInstruction || irqEntry) begin // [RULE6]
			irqEn_next = 1'b0;
		end else if (irqEnableInstruction || irqReturnInstruction) begin // [RULE6]
			irqEn_next = 1'b1;
		end
		extIrq_next = tick_reg[EDGE_BIT] ? fall[1] : rise[1]; // [RULE5]
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			irqEn_reg <= 1'b0;
			extIrq_reg <= 1'b0;
		end else if (ce) begin
			irqEn_reg <= irqEn_next;
			extIrq_reg <= extIrq_next;
		end
	end

	// Tick source; the pin is only edge sampled, so it must be slower than the core
	assign tickSrc = tick_reg[SRC_BIT] // [RULE7]
		? (tick_reg[CEDGE_BIT] ? fall[0] : rise[0]) // [RULE8] [RULE9]
		: instrTick;
	assign tickShift = tick_reg[TICK_PRESCALE_ON_BIT] ? twk_shift(tick_reg[2:0], 1'b1) : 4'h0; // [RULE10]

	// Time clock prescaler, cleared by any counter write
	twk_prescaler #(.WIDTH(8)) tickPre (
		.clk(clk),
		.nrst(nrst),
		.ce(ce),
		.tickIn(tickSrc),
		.clear(tickCounterWrite), // [RULE19]
		.shift(tickShift),
		.tickOut(tickPulse)
	);

	// Down-counter clock sources
	assign cnt1Src = cnt_reg[CNT1_SEL_BIT] ? rise[3] : rise[2]; // [RULE16]
	assign cnt2Src = cnt_reg[CNT2_SEL_BIT] ? rise[3] : rise[2]; // [RULE14]

	twk_prescaler #(.WIDTH(8)) cnt1Pre (
		.clk(clk),
		.nrst(nrst),
		.ce(ce),
		.tickIn(cnt1Src),
		.clear(1'b0),
		.shift(twk_shift(cnt_reg[CODE_LSB +: 3], 1'b1)), // [RULE17]
		.tickOut(counterOneTick)
	);

	twk_prescaler #(.WIDTH(8)) cnt2Pre (
		.clk(clk),
		.nrst(nrst),
		.ce(ce),
		.tickIn(cnt2Src),
		.clear(1'b0),
		.shift(twk_shift(cnt_reg[CNT2_CODE_LSB +: 3], 1'b1)), // [RULE15]
		.tickOut(counterTwoTick)
	);

	// Watchdog runs from the sub oscillator only, at half its rate
	assign wdHalfTick = rise[2] && half_reg; // [RULE13]
	assign wdClear = watchdogClearInstruction || sleepInstruction || !wdog_reg[WDOG_ON_BIT]; // [RULE11] [RULE19]

	twk_prescaler #(.WIDTH(8)) wdPre (
		.clk(clk),
		.nrst(nrst),
		.ce(ce),
		.tickIn(wdHalfTick),
		.clear(wdClear),
		.shift(twk_shift(wdog_reg[CODE_LSB +: 3], 1'b0)), // [RULE12]
		.tickOut(wdStep)
	);

	// Main watchdog count: 256 prescaler steps then a reset pulse
	always_comb begin
		half_next = rise[2] ? ~half_reg : half_reg;
		wdCnt_next = wdCnt_reg;
		wdRst_next = 1'b0;
		if (wdClear) begin
			wdCnt_next = 8'h00;
		end else if (wdStep) begin
			wdCnt_next = wdCnt_reg + 8'h01;
			wdRst_next = (wdCnt_reg == WDOG_LAST); // [RULE18]
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			half_reg <= 1'b0;
			wdCnt_reg <= 8'h00;
			wdRst_reg <= 1'b0;
		end else if (ce) begin
			half_reg <= half_next;
			wdCnt_reg <= wdCnt_next;
			wdRst_reg <= wdRst_next;
		end
	end

	// Read path; other pages and addresses return zero with valid set
	always_comb begin
		rd_next = 8'h00;
		rdValid_next = regReq.rd;
		if (regReq.rd && twk_hit(regReq, ADDR_WAKE)) begin // [RULE1]
			rd_next = wake_reg & WAKE_MASK; // [RULE21]
		end else if (regReq.rd && twk_hit(regReq, ADDR_TICK)) begin
			rd_next = (tick_reg & TICK_MASK) | {1'b0, irqEn_reg, 6'h00}; // [RULE6]
		end else if (regReq.rd && twk_hit(regReq, ADDR_WDOG)) begin
			rd_next = wdog_reg & WDOG_MASK; // [RULE21]
		end else if (regReq.rd && twk_hit(regReq, ADDR_CNT)) begin
			rd_next = cnt_reg;
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			rd_reg <= 8'h00;
			rdValid_reg <= 1'b0;
		end else if (ce) begin
			rd_reg <= rd_next;
			rdValid_reg <= rdValid_next;
		end
	end

	// Outputs straight from flops
	assign regRdData = rd_reg;
	assign regRdValid = rdValid_reg;
	assign irPinDriveSelect = wake_reg[IR_DRIVE_BIT]; // [RULE2]
	assign wakeDisable = wake_reg[3:0]; // [RULE3]
	assign globalIrqEnable = irqEn_reg;
	assign extIrqPulse = extIrq_reg;
	assign watchdogReset = wdRst_reg;

	// Checks
	property p_page_gate;
		@(posedge clk) disable iff (!nrst)
		(ce && regReq.wr && !regReq.page)
			|=> $stable(wake_reg) && $stable(wdog_reg) && $stable(tick_reg) && $stable(cnt_reg);
	endproperty
	a_page_gate: assert property (p_page_gate) else $error("page zero write changed a register"); // [RULE1]

	property p_wake_write;
		@(posedge clk) disable iff (!nrst)
		(ce && regReq.wr && regReq.page && regReq.addr == ADDR_WAKE)
			|=> wakeDisable == $past(regReq.wdata[3:0]) && wake_reg[6:4] == 3'h0;
	endproperty
	a_wake_write: assert property (p_wake_write) else $error("wake write not taken"); // [RULE3]

	property p_irq_copy;
		@(posedge clk) disable iff (!nrst)
		(ce && regReq.rd && regReq.page && regReq.addr == ADDR_TICK)
			|=> regRdData[IRQEN_BIT] == $past(irqEn_reg);
	endproperty
	a_irq_copy: assert property (p_irq_copy) else $error("irq enable copy wrong"); // [RULE6]

	property p_irq_off;
		@(posedge clk) disable iff (!nrst)
		(ce && irqEntry) |=> !globalIrqEnable;
	endproperty
	a_irq_off: assert property (p_irq_off) else $error("irq enable not cleared"); // [RULE6]

	property p_bypass;
		@(posedge clk) disable iff (!nrst)
		(ce && !tick_reg[TICK_PRESCALE_ON_BIT] && !tick_reg[SRC_BIT] && instrTick && !tickCounterWrite)
			|=> tickPulse;
	endproperty
	a_bypass: assert property (p_bypass) else $error("bypassed tick missing"); // [RULE10]

	property p_wdog_off;
		@(posedge clk) disable iff (!nrst)
		(!wdog_reg[WDOG_ON_BIT]) |=> !watchdogReset;
	endproperty
	a_wdog_off: assert property (p_wdog_off) else $error("disabled watchdog reset"); // [RULE11]

	property p_wdog_clear;
		@(posedge clk) disable iff (!nrst)
		(ce && (watchdogClearInstruction || sleepInstruction)) |=> wdCnt_reg == 8'h00;
	endproperty
	a_wdog_clear: assert property (p_wdog_clear) else $error("watchdog not cleared"); // [RULE19]

	property p_wdog_cause;
		@(posedge clk) disable iff (!nrst)
		watchdogReset |-> $past(wdCnt_reg) == WDOG_LAST && $past(wdStep);
	endproperty
	a_wdog_cause: assert property (p_wdog_cause) else $error("watchdog reset early"); // [RULE18]

	// Low enable must freeze the four control registers, the watchdog count and the interrupt enable
	property p_freeze;
		@(posedge clk) disable iff (!nrst)
		(!ce) |=> $stable(wake_reg) && $stable(tick_reg) && $stable(wdog_reg)
			&& $stable(cnt_reg) && $stable(wdCnt_reg) && $stable(irqEn_reg);
	endproperty
	a_freeze: assert property (p_freeze) else $error("state moved with enable low");

	property p_reserved;
		@(posedge clk) disable iff (!nrst)
		wake_reg[6:4] == 3'h0 && wdog_reg[7:4] == 4'h0 && !tick_reg[IRQEN_BIT];
	endproperty
	a_reserved: assert property (p_reserved) else $error("reserved bit stored"); // [RULE21]

	property p_rd_valid;
		@(posedge clk) disable iff (!nrst)
		(ce && regReq.rd) |=> regRdValid;
	endproperty
	a_rd_valid: assert property (p_rd_valid) else $error("read not answered"); // [RULE1]

	// Other page must never leak a register value
	property p_unmapped;
		@(posedge clk) disable iff (!nrst)
		(ce && regReq.rd && !regReq.page) |=> regRdData == 8'h00;
	endproperty
	a_unmapped: assert property (p_unmapped) else $error("page zero read not zero"); // [RULE1]

	property p_irq_on;
		@(posedge clk) disable iff (!nrst)
		(ce && (irqEnableInstruction || irqReturnInstruction) && !irqDisableInstruction
			&& !irqEntry) |=> globalIrqEnable;
	endproperty
	a_irq_on: assert property (p_irq_on) else $error("irq enable not set"); // [RULE6]

	property p_ext_edge;
		@(posedge clk) disable iff (!nrst)
		(ce && syncB_reg[1] != prev_reg[1] && syncB_reg[1] == !tick_reg[EDGE_BIT])
			|=> extIrqPulse;
	endproperty
	a_ext_edge: assert property (p_ext_edge) else $error("selected irq edge missed"); // [RULE5]

	property p_tick_clear;
		@(posedge clk) disable iff (!nrst)
		(ce && tickCounterWrite) |=> !tickPulse;
	endproperty
	a_tick_clear: assert property (p_tick_clear) else $error("tick through a clear"); // [RULE19]

	// Half-rate phase may only move on a sub oscillator rise
	property p_wdog_sub;
		@(posedge clk) disable iff (!nrst)
		(ce && !(syncB_reg[2] && !prev_reg[2])) |=> $stable(half_reg);
	endproperty
	a_wdog_sub: assert property (p_wdog_sub) else $error("watchdog moved off sub clock"); // [RULE13]

endmodule : twk_control

/* rtl/twk_pkg.sv */
// Constants, types and helpers shared by the timer, watchdog and wake control block
// Notes on behaviour
// RULE1: All four control registers answer only while the page select bit is one.
// RULE2: Wake register bit 7 picks normal or doubled sink drive on the infrared pin.
// RULE3: Wake register bits 3..0 disable pin-change wake per nibble; zero enables.
// RULE4: After reset every pin-change wake group is enabled.
// RULE5: Tick register bit 7 picks rising (0) or falling (1) external interrupt edge.
// RULE6: Tick register bit 6 reads the global interrupt enable; writes ignored.
// RULE7: Tick register bit 5 picks instruction clock (0) or external pin (1) as source.
// RULE8: External tick pin period must exceed the instruction clock period.
// RULE9: Tick register bit 4 counts rising (0) or falling (1) external pin edges.
// RULE10: Prescaler bypassed when bit 3 is zero, else divides by two to code plus one.
// RULE11: Watchdog register bit 3 enables the watchdog.
// RULE12: Watchdog register bits 2..0 divide by two to the power of the code.
// RULE13: Watchdog counts only on the sub-oscillator clock.
// RULE14: Counter clock register bit 7 picks sub (0) or main (1) clock for counter two.
// RULE15: Counter clock bits 6..4 divide counter two by two to code plus one.
// RULE16: Counter clock register bit 3 picks sub (0) or main (1) clock for counter one.
// RULE17: Counter clock bits 2..0 divide counter one by two to code plus one.
// RULE18: Watchdog times out after ratio times 256 half-rate periods and resets the device.
// RULE19: Counter write clears the tick prescaler; clear and sleep clear the watchdog.
// RULE20: Tick register resets to all ones except the read-only bit 6.
// RULE21: Unused wake and watchdog bits ignore writes and read zero.
package twk_pkg;

	// Register addresses within the page
	localparam logic [3:0] ADDR_WAKE = 4'h6;
	localparam logic [3:0] ADDR_TICK = 4'h7;
	localparam logic [3:0] ADDR_WDOG = 4'h8;
	localparam logic [3:0] ADDR_CNT = 4'h9;

	// Writable bit masks
	localparam logic [7:0] WAKE_MASK = 8'h8F;
	localparam logic [7:0] TICK_MASK = 8'hBF;
	localparam logic [7:0] WDOG_MASK = 8'h0F;
	localparam logic [7:0] CNT_MASK = 8'hFF;

	// Values after reset
	localparam logic [7:0] WAKE_RST = 8'h00;
	localparam logic [7:0] TICK_RST = 8'hBF;
	localparam logic [7:0] WDOG_RST = 8'h00;
	localparam logic [7:0] CNT_RST = 8'h00;

	// Field positions
	localparam int IR_DRIVE_BIT = 7;
	localparam int EDGE_BIT = 7;
	localparam int IRQEN_BIT = 6;
	localparam int SRC_BIT = 5;
	localparam int CEDGE_BIT = 4;
	localparam int TICK_PRESCALE_ON_BIT = 3;
	localparam int WDOG_ON_BIT = 3;
	localparam int CNT2_SEL_BIT = 7;
	localparam int CNT2_CODE_LSB = 4;
	localparam int CNT1_SEL_BIT = 3;
	localparam int CODE_LSB = 0;

	// Watchdog main count is 256 prescaler steps, each of two to the code half-rate periods
	localparam logic [7:0] WDOG_LAST = 8'hFF;

	// One register access from the core
	typedef struct packed {
		logic wr;
		logic rd;
		logic page;
		logic [3:0] addr;
		logic [7:0] wdata;
	} twk_reg_req_t;

	// Divide code to shift amount, optionally one step up
	function automatic logic [3:0] twk_shift(input logic [2:0] code, input logic plusOne);
		return {1'b0, code} + {3'h0, plusOne};
	endfunction : twk_shift

	// Access hits a given register of this page
	function automatic logic twk_hit(input twk_reg_req_t req, input logic [3:0] addr);
		return req.page && (req.addr == addr);
	endfunction : twk_hit

endpackage : twk_pkg

/* rtl/twk_prescaler.sv */
// Power-of-two tick divider with synchronous clear
module twk_prescaler #(
	parameter int WIDTH = 8
) (
	// Clock, enable and reset
	input wire logic clk,
	input wire logic nrst,
	input wire logic ce,
	// Ticks and control
	input wire logic tickIn,
	input wire logic clear,
	input wire logic [3:0] shift,
	output logic tickOut
);
	logic [WIDTH-1:0] cnt_reg, cnt_next;
	logic tick_reg, tick_next;
	logic [WIDTH:0] full;

	// Next count; shift of zero passes every tick
	always_comb begin
		full = ({{WIDTH{1'b0}}, 1'b1} << shift) - {{WIDTH{1'b0}}, 1'b1};
		cnt_next = cnt_reg;
		tick_next = 1'b0;
		if (clear) begin
			cnt_next = '0;
		end else if (tickIn) begin
			if (cnt_reg >= full[WIDTH-1:0]) begin
				cnt_next = '0;
				tick_next = 1'b1;
			end else begin
				cnt_next = cnt_reg + {{(WIDTH-1){1'b0}}, 1'b1};
			end
		end
	end

	// Register stage
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			cnt_reg <= '0;
			tick_reg <= 1'b0;
		end else if (ce) begin
			cnt_reg <= cnt_next;
			tick_reg <= tick_next;
		end
	end

	assign tickOut = tick_reg;

endmodule : twk_prescaler
